// *** rtl/dcil_pkg.sv ***
// Package: constants and carrier types for the drive command input logic
package dcil_pkg;

    // ==========================================
    // Command source selector codes
    localparam logic [2:0] DCIL_CMD_FACTORY  = 3'h0;
    localparam logic [2:0] DCIL_CMD_DIGITAL  = 3'h2;
    localparam logic [2:0] DCIL_CMD_SERIAL   = 3'h4;
    localparam logic [2:0] DCIL_CMD_FIELDBUS = 3'h6;

    // ==========================================
    // Wire method selector
    localparam logic [1:0] DCIL_WIRE_3W_M2   = 2'h3;

    // ==========================================
    // Input function codes
    localparam logic [6:0] DCIL_FN_DISABLED  = 7'h00;
    localparam logic [6:0] DCIL_FN_ON_RSTOP  = 7'h01;
    localparam logic [6:0] DCIL_FN_REV_ON    = 7'h02;
    localparam logic [6:0] DCIL_FN_COAST     = 7'h03;
    localparam logic [6:0] DCIL_FN_QUICK     = 7'h04;
    localparam logic [6:0] DCIL_FN_FAULT_ACK = 7'h09;
    localparam logic [6:0] DCIL_FN_JOG_R     = 7'h0A;
    localparam logic [6:0] DCIL_FN_JOG_L     = 7'h0B;
    localparam logic [6:0] DCIL_FN_REVERSE   = 7'h0C;
    localparam logic [6:0] DCIL_FN_POT_UP    = 7'h0D;
    localparam logic [6:0] DCIL_FN_POT_DOWN  = 7'h0E;
    localparam logic [6:0] DCIL_FN_FF_BIT0   = 7'h0F;
    localparam logic [6:0] DCIL_FN_FF_BIT3   = 7'h12;
    localparam logic [6:0] DCIL_FN_HALT_SRC1 = 7'h16;
    localparam logic [6:0] DCIL_FN_HALT_SRC2 = 7'h17;
    localparam logic [6:0] DCIL_FN_HALT_OVR  = 7'h18;
    localparam logic [6:0] DCIL_FN_DC_BRAKE  = 7'h19;
    localparam logic [6:0] DCIL_FN_PID_EN    = 7'h1B;
    localparam logic [6:0] DCIL_FN_EXT_TRIP  = 7'h1D;
    localparam logic [6:0] DCIL_FN_NO_ADDSP  = 7'h21;
    localparam logic [6:0] DCIL_FN_ROUTED    = 7'h63;

    // ==========================================
    // Factory input functions
    localparam logic [6:0] DCIL_RST_FN0      = DCIL_FN_ON_RSTOP;
    localparam logic [6:0] DCIL_RST_FN1      = DCIL_FN_REVERSE;
    localparam logic [6:0] DCIL_RST_FN2      = DCIL_FN_FAULT_ACK;
    localparam logic [6:0] DCIL_RST_FN3      = DCIL_FN_FF_BIT0;

    // ==========================================
    // Setpoint source selector codes
    localparam logic [2:0] DCIL_SP_NONE      = 3'h0;
    localparam logic [2:0] DCIL_SP_POT       = 3'h1;
    localparam logic [2:0] DCIL_SP_ANALOG    = 3'h2;
    localparam logic [2:0] DCIL_SP_FIXED     = 3'h3;
    localparam logic [2:0] DCIL_SP_SERIAL    = 3'h4;
    localparam logic [2:0] DCIL_SP_FIELDBUS  = 3'h6;

    localparam logic [1:0] DCIL_ACCESS_EXT   = 2'h2;

    // ==========================================
    // Types
    typedef enum logic [1:0] {
        DCIL_ST_IDLE = 2'b00,
        DCIL_ST_RUN  = 2'b01,
        DCIL_ST_STOP = 2'b10
    } dcil_mode_e;

    typedef struct packed {
        logic ramp_stop;
        logic coast_stop;
        logic quick_ramp_stop;
        logic fault_ack;
        logic jog_right;
        logic jog_left;
        logic pot_up;
        logic pot_down;
        logic halt_src1;
        logic halt_src2;
        logic halt_override;
        logic dc_brake;
        logic pid_enable;
        logic ext_trip;
        logic no_add_setpoint;
    } dcil_func_s;

    typedef struct packed {
        logic run_on;
        logic dir_reverse;
        logic accel_pulse;
        logic reverse_pulse;
        logic cmd_digital;
        logic cmd_serial;
        logic cmd_fieldbus;
        logic cmd_factory;
    } dcil_cmd_s;

    typedef struct packed {
        logic [3:0]   din;
        logic [3:0]   din_prev;
        logic [6:0]   fn0;
        logic [6:0]   fn1;
        logic [6:0]   fn2;
        logic [6:0]   fn3;
        logic [3:0]   routed;
        dcil_mode_e   mode;
        logic         dir;
        dcil_func_s   func;
        logic [3:0]   ff_sel;
        logic [3:0]   routed_din;
        dcil_cmd_s    cmd;
        logic [5:0]   sp_onehot;
        logic [2:0]   cmd_src;
    } dcil_state_s;

endpackage

// *** rtl/dcil_top.sv ***
// Drive command input logic: command source, input functions, three-wire method 2
`timescale 1ns/1ps
// Function
// (R1) Enable is a level; dropping it stops
// (R2) Start only on run rising edge
// (R3) Reverse level gives commanded direction
// (R4) Enable low: ignore run, ramp-stop if rotating
// (R5) Stationary run edge: accelerate, direction from reverse
// (R6) Rotating, run low: reverse edges reverse motor
// (R7) Method 2 when wire 3, source digital
// (R8) Configure inputs 0,1,2 as enable/start/reverse; factory functions give them codes 1, 12 and 9 instead
// (R9) Decode command source selector 0/2/4/6
// (R10) Fieldbus variant defaults command source to 6
// (R11) Factory input functions after factory reset
// (R12) Decode function codes 0 to 4
// (R13) Decode function codes 9 to 14
// (R14) Codes 15-18 drive fixed-frequency bits 0-3
// (R15) Decode quick-stop, brake, PID, trip codes
// (R16) Code 99 inputs routed by outside configuration
// (R17) Code 99 locked until factory restore
// (R18) Decode setpoint source selector
// (R19) Function changes only at access level 2
// (R20) Sample inputs; edges from previous sample
// (R21) Stationary status input picks behaviour
module dcil_top #(
    parameter bit HAS_FIELDBUS = 1'b1
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic [3:0]            digital_in,
    input  wire logic                  motor_stationary,
    input  wire logic [2:0]            command_source_sel,
    input  wire logic [1:0]            wire_method_sel,
    input  wire logic [2:0]            setpoint_source_sel,
    input  wire logic [1:0]            param_access_level,
    input  wire logic                  fn_write,
    input  wire logic [1:0]            fn_write_index,
    input  wire logic [6:0]            fn_write_value,
    input  wire logic                  factory_restore,
    output logic [6:0]                 input0_function_sel,
    output logic [6:0]                 input1_function_sel,
    output logic [6:0]                 input2_function_sel,
    output logic [6:0]                 input3_function_sel,
    output logic                       fn_write_refused,
    output logic [2:0]                 command_source_eff,
    output dcil_pkg::dcil_cmd_s        cmd_out,
    output dcil_pkg::dcil_func_s       func_out,
    output logic [3:0]                 fixed_freq_sel,
    output logic [3:0]                 routed_inputs,
    output logic [5:0]                 setpoint_source_onehot,
    output logic                       method2_active
);
    import dcil_pkg::*;

    dcil_state_s s_r;
    dcil_state_s s_nxt;
    logic        refused_r;
    logic        refused_nxt;

    logic [6:0]  fn     [4];
    logic [3:0]  rise;
    logic [3:0]  fall;
    logic [2:0]  src_eff;
    logic        m2;
    logic        en_lvl;
    logic        run_rise;
    logic        rev_lvl;
    logic        rev_rise;
    logic        rev_fall;
    logic        run_lvl;
    logic        lock;

    // ==========================================
    // Command source and method selection
    always_comb begin
        fn[0] = s_r.fn0;
        fn[1] = s_r.fn1;
        fn[2] = s_r.fn2;
        fn[3] = s_r.fn3;
        // (R10) Fieldbus variant default
        if (command_source_sel == DCIL_CMD_FACTORY) begin
            src_eff = HAS_FIELDBUS ? DCIL_CMD_FIELDBUS : DCIL_CMD_DIGITAL;
        end else begin
            src_eff = command_source_sel;
        end
        // (R7) Method 2 selection
        m2 = (wire_method_sel == DCIL_WIRE_3W_M2) && (src_eff == DCIL_CMD_DIGITAL);
        // (R20) Edge detection
        rise = s_r.din & ~s_r.din_prev;
        fall = ~s_r.din & s_r.din_prev;
    end

    // Role gathering is an OR over inputs, so input 3 may stand in for any role
    always_comb begin
        en_lvl   = 1'b0;
        run_lvl  = 1'b0;
        run_rise = 1'b0;
        rev_lvl  = 1'b0;
        rev_rise = 1'b0;
        rev_fall = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (fn[i] == DCIL_FN_REV_ON) begin
                en_lvl = en_lvl | s_r.din[i];
            end
            if (fn[i] == DCIL_FN_ON_RSTOP) begin
                run_lvl  = run_lvl | s_r.din[i];
                run_rise = run_rise | rise[i];
            end
            if (fn[i] == DCIL_FN_REVERSE) begin
                rev_lvl  = rev_lvl | s_r.din[i];
                rev_rise = rev_rise | rise[i];
                rev_fall = rev_fall | fall[i];
            end
        end
    end

    always_comb begin
        s_nxt       = s_r;
        refused_nxt = 1'b0;
        lock        = 1'b0;
        // (R20) Input sampling
        s_nxt.din      = digital_in;
        s_nxt.din_prev = s_r.din;
        s_nxt.cmd_src  = src_eff;

        // ==========================================
        // Function selector writes
        if (factory_restore) begin
            // (R11) Factory input functions
            s_nxt.fn0 = DCIL_RST_FN0;
            s_nxt.fn1 = DCIL_RST_FN1;
            s_nxt.fn2 = DCIL_RST_FN2;
            s_nxt.fn3 = DCIL_RST_FN3;
        end else if (fn_write) begin
            // (R17) Routed code is locked
            lock = (fn[fn_write_index] == DCIL_FN_ROUTED);
            // (R19) Extended access needed
            if (param_access_level != DCIL_ACCESS_EXT || lock) begin
                refused_nxt = 1'b1;
            end else begin
                case (fn_write_index)
                    2'd0:    s_nxt.fn0 = fn_write_value;
                    2'd1:    s_nxt.fn1 = fn_write_value;
                    2'd2:    s_nxt.fn2 = fn_write_value;
                    default: s_nxt.fn3 = fn_write_value;
                endcase
            end
        end

        // ==========================================
        // Per-input function decode
        s_nxt.func   = '0;
        s_nxt.ff_sel = 4'h0;
        s_nxt.routed = 4'h0;
        for (int i = 0; i < 4; i++) begin
            case (fn[i])
                // (R12) Basic stop codes
                DCIL_FN_COAST:     s_nxt.func.coast_stop      = s_nxt.func.coast_stop | s_r.din[i];
                DCIL_FN_QUICK:     s_nxt.func.quick_ramp_stop = s_nxt.func.quick_ramp_stop | s_r.din[i];
                // (R13) Jog, ack, pot codes
                DCIL_FN_FAULT_ACK: s_nxt.func.fault_ack       = s_nxt.func.fault_ack | s_r.din[i];
                DCIL_FN_JOG_R:     s_nxt.func.jog_right       = s_nxt.func.jog_right | s_r.din[i];
                DCIL_FN_JOG_L:     s_nxt.func.jog_left        = s_nxt.func.jog_left | s_r.din[i];
                DCIL_FN_POT_UP:    s_nxt.func.pot_up          = s_nxt.func.pot_up | s_r.din[i];
                DCIL_FN_POT_DOWN:  s_nxt.func.pot_down        = s_nxt.func.pot_down | s_r.din[i];
                // (R15) Halt, brake, trip codes
                DCIL_FN_HALT_SRC1: s_nxt.func.halt_src1       = s_nxt.func.halt_src1 | s_r.din[i];
                DCIL_FN_HALT_SRC2: s_nxt.func.halt_src2       = s_nxt.func.halt_src2 | s_r.din[i];
                DCIL_FN_HALT_OVR:  s_nxt.func.halt_override   = s_nxt.func.halt_override | s_r.din[i];
                DCIL_FN_DC_BRAKE:  s_nxt.func.dc_brake        = s_nxt.func.dc_brake | s_r.din[i];
                DCIL_FN_PID_EN:    s_nxt.func.pid_enable      = s_nxt.func.pid_enable | s_r.din[i];
                DCIL_FN_EXT_TRIP:  s_nxt.func.ext_trip        = s_nxt.func.ext_trip | s_r.din[i];
                DCIL_FN_NO_ADDSP:  s_nxt.func.no_add_setpoint = s_nxt.func.no_add_setpoint | s_r.din[i];
                // (R16) Raw input for outside routing
                DCIL_FN_ROUTED:    s_nxt.routed[i]            = 1'b1;
                default: begin
                end
            endcase
            // (R14) Fixed-frequency bits
            if (fn[i] >= DCIL_FN_FF_BIT0 && fn[i] <= DCIL_FN_FF_BIT3) begin
                s_nxt.ff_sel[fn[i][1:0] - DCIL_FN_FF_BIT0[1:0]] = s_nxt.ff_sel[fn[i][1:0] - DCIL_FN_FF_BIT0[1:0]]
                                                                 | s_r.din[i];
            end
        end
        s_nxt.routed_din = s_r.din & s_r.routed;

        // ==========================================
        // Run command generation
        s_nxt.cmd.accel_pulse   = 1'b0;
        s_nxt.cmd.reverse_pulse = 1'b0;
        // (R9) Command source decode
        s_nxt.cmd.cmd_digital  = (src_eff == DCIL_CMD_DIGITAL);
        s_nxt.cmd.cmd_serial   = (src_eff == DCIL_CMD_SERIAL);
        s_nxt.cmd.cmd_fieldbus = (src_eff == DCIL_CMD_FIELDBUS);
        s_nxt.cmd.cmd_factory  = (src_eff == DCIL_CMD_FACTORY);
        if (m2) begin
            case (s_r.mode)
                DCIL_ST_IDLE: begin
                    // (R2) Edge-started run
                    if (en_lvl && run_rise && motor_stationary) begin
                        // (R5) Direction from reverse level
                        s_nxt.dir             = rev_lvl;
                        s_nxt.mode            = DCIL_ST_RUN;
                        s_nxt.cmd.accel_pulse = 1'b1;
                    end
                end
                DCIL_ST_RUN: begin
                    // (R1) Enable drop stops
                    if (!en_lvl) begin
                        s_nxt.mode = DCIL_ST_STOP;
                    // (R6) Reverse while rotating
                    end else if (!motor_stationary && !run_lvl && (rev_rise || rev_fall)) begin
                        // (R3) Reverse level is direction
                        s_nxt.dir               = rev_rise;
                        s_nxt.cmd.reverse_pulse = 1'b1;
                    end
                end
                DCIL_ST_STOP: begin
                    // (R4) Ramp to standstill, inputs ignored
                    // (R21) Standstill ends the stop
                    if (motor_stationary) begin
                        s_nxt.mode = DCIL_ST_IDLE;
                    end
                end
                default: s_nxt.mode = DCIL_ST_IDLE;
            endcase
        end else begin
            s_nxt.mode = DCIL_ST_IDLE;
        end
        s_nxt.cmd.run_on      = (s_nxt.mode == DCIL_ST_RUN);
        s_nxt.cmd.dir_reverse = s_nxt.dir;
        s_nxt.func.ramp_stop  = m2 && (s_nxt.mode == DCIL_ST_STOP);

        // ==========================================
        // (R18) Setpoint source decode
        s_nxt.sp_onehot = 6'h00;
        case (setpoint_source_sel)
            DCIL_SP_NONE:     s_nxt.sp_onehot = 6'h01;
            DCIL_SP_POT:      s_nxt.sp_onehot = 6'h02;
            DCIL_SP_ANALOG:   s_nxt.sp_onehot = 6'h04;
            DCIL_SP_FIXED:    s_nxt.sp_onehot = 6'h08;
            DCIL_SP_SERIAL:   s_nxt.sp_onehot = 6'h10;
            DCIL_SP_FIELDBUS: s_nxt.sp_onehot = 6'h20;
            default:          s_nxt.sp_onehot = 6'h00;
        endcase
    end

    // ==========================================
    // State register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_r       <= '0;
            s_r.fn0   <= DCIL_RST_FN0;
            s_r.fn1   <= DCIL_RST_FN1;
            s_r.fn2   <= DCIL_RST_FN2;
            s_r.fn3   <= DCIL_RST_FN3;
            s_r.mode  <= DCIL_ST_IDLE;
            refused_r <= 1'b0;
        end else begin
            s_r       <= s_nxt;
            refused_r <= refused_nxt;
        end
    end

    assign input0_function_sel    = s_r.fn0;
    assign input1_function_sel    = s_r.fn1;
    assign input2_function_sel    = s_r.fn2;
    assign input3_function_sel    = s_r.fn3;
    assign fn_write_refused       = refused_r;
    assign command_source_eff     = s_r.cmd_src;
    assign cmd_out                = s_r.cmd;
    assign func_out               = s_r.func;
    assign fixed_freq_sel         = s_r.ff_sel;
    assign routed_inputs          = s_r.routed_din;
    assign setpoint_source_onehot = s_r.sp_onehot;
    assign method2_active         = (s_r.cmd_src == DCIL_CMD_DIGITAL) && (wire_method_sel == DCIL_WIRE_3W_M2);
endmodule

// *** tb/dcil_properties.sv ***
// Checker: concurrent properties on the command input logic ports
`timescale 1ns/1ps
module dcil_properties
    import dcil_pkg::*;
#(
    parameter bit HAS_FIELDBUS = 1'h1
) (
    input wire logic                 ref_clk,
    input wire logic                 reset,
    input wire logic [3:0]           digital_in,
    input wire logic                 motor_stationary,
    input wire logic [2:0]           command_source_sel,
    input wire logic [1:0]           wire_method_sel,
    input wire logic [2:0]           setpoint_source_sel,
    input wire logic [1:0]           param_access_level,
    input wire logic                 fn_write,
    input wire logic [1:0]           fn_write_index,
    input wire logic [6:0]           fn_write_value,
    input wire logic                 factory_restore,
    input wire logic [6:0]           input0_function_sel,
    input wire logic [6:0]           input1_function_sel,
    input wire logic [6:0]           input2_function_sel,
    input wire logic [6:0]           input3_function_sel,
    input wire logic                 fn_write_refused,
    input wire logic [2:0]           command_source_eff,
    input wire dcil_pkg::dcil_cmd_s  cmd_out,
    input wire dcil_pkg::dcil_func_s func_out,
    input wire logic [3:0]           fixed_freq_sel,
    input wire logic [3:0]           routed_inputs,
    input wire logic [5:0]           setpoint_source_onehot,
    input wire logic                 method2_active
);
    // ==========================================
    // Properties
    // Role guards: inputs 0..2, and input 3 in a_enable_level
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_accel_cause: assert property (
        cmd_out.accel_pulse && input1_function_sel == DCIL_FN_ON_RSTOP && input0_function_sel == DCIL_FN_REV_ON
        |-> $past(digital_in[1], 2) && !$past(digital_in[1], 3) && $past(digital_in[0], 2) && $past(motor_stationary))
        else $error("accel pulse without enabled start edge at standstill");
    a_accel_dir: assert property (
        cmd_out.accel_pulse && input2_function_sel == DCIL_FN_REVERSE |-> cmd_out.dir_reverse == $past(digital_in[2], 2))
        else $error("start direction differs from reverse level");
    a_enable_level: assert property (
        method2_active && $past(method2_active, 2) && input0_function_sel == DCIL_FN_REV_ON
        && input3_function_sel != DCIL_FN_REV_ON && !$past(digital_in[0], 2) |-> !cmd_out.run_on)
        else $error("run kept while enable low");
    a_reverse_cause: assert property (
        cmd_out.reverse_pulse && input2_function_sel == DCIL_FN_REVERSE && input1_function_sel == DCIL_FN_ON_RSTOP
        |-> $past(digital_in[2], 2) != $past(digital_in[2], 3) && !$past(digital_in[1], 2) && !$past(motor_stationary)
        && cmd_out.dir_reverse == $past(digital_in[2], 2))
        else $error("reverse pulse without rotating reverse edge");
    a_refused_level: assert property (
        fn_write && !factory_restore && param_access_level != DCIL_ACCESS_EXT
        |=> fn_write_refused && $stable({input0_function_sel, input1_function_sel, input2_function_sel, input3_function_sel}))
        else $error("write below extended level not refused");
    a_write_lands: assert property (
        fn_write && !factory_restore && param_access_level == DCIL_ACCESS_EXT && fn_write_index == 2'h3
        && input3_function_sel != DCIL_FN_ROUTED |=> input3_function_sel == $past(fn_write_value) && !fn_write_refused)
        else $error("permitted write did not land");
    a_lock_routed: assert property (
        fn_write && !factory_restore && fn_write_index == 2'h3 && input3_function_sel == DCIL_FN_ROUTED
        |=> input3_function_sel == DCIL_FN_ROUTED && fn_write_refused)
        else $error("routed selector changed without restore");
    a_restore_factory: assert property (
        factory_restore |=> {input0_function_sel, input1_function_sel, input2_function_sel, input3_function_sel}
        == {DCIL_RST_FN0, DCIL_RST_FN1, DCIL_RST_FN2, DCIL_RST_FN3})
        else $error("restore did not give factory functions");
    a_src_default: assert property (
        !$past(reset) && $past(command_source_sel) == DCIL_CMD_FACTORY
        |-> command_source_eff == (HAS_FIELDBUS ? DCIL_CMD_FIELDBUS : DCIL_CMD_DIGITAL))
        else $error("factory source not mapped to default");
    a_sp_fixed: assert property (
        !$past(reset) && $past(setpoint_source_sel) == DCIL_SP_FIXED |-> setpoint_source_onehot == 6'h08)
        else $error("fixed setpoint source not decoded");
    a_method_sel: assert property (
        !$past(reset) |-> method2_active == (wire_method_sel == DCIL_WIRE_3W_M2 && ($past(command_source_sel)
        == DCIL_CMD_DIGITAL || (!HAS_FIELDBUS && $past(command_source_sel) == DCIL_CMD_FACTORY))))
        else $error("method 2 active outside its selection");
endmodule

// *** tb/dcil_switches.sv ***
// Partner model: field switches or a controller driving the four digital inputs
`timescale 1ns/1ps
module dcil_switches (
    input  wire logic       ref_clk,
    input  wire logic       en_req,
    input  wire logic       run_req,
    input  wire logic       rev_req,
    input  wire logic       aux_req,
    output logic [3:0]      digital_in
);
    // ==========================================
    // Contacts
    initial digital_in = 4'h0;
    // enable, start, reverse on inputs 0..2
    // Contacts move just after an edge, so no sample ever straddles a change
    always @(posedge ref_clk) begin
        digital_in <= {aux_req, rev_req, run_req, en_req};
    end
endmodule

// *** tb/dcil_top_test.sv ***
// Testbench: self-checking scenarios for the drive command input logic
`timescale 1ns/1ps
module dcil_top_test;
    import dcil_pkg::*;
    logic ref_clk = 1'h0, reset = 1'h1, motor_stationary = 1'h1, fn_write = 1'h0, factory_restore = 1'h0;
    logic en = 1'h0, run = 1'h0, rev = 1'h0, aux = 1'h0, rf;
    logic [2:0] command_source_sel = 3'h0, setpoint_source_sel = 3'h3;
    logic [1:0] wire_method_sel = 2'h0, param_access_level = 2'h1, fn_write_index = 2'h0;
    logic [6:0] fn_write_value = 7'h00, sel0, sel1, sel2, sel3;
    logic [3:0] digital_in, fixed_freq_sel, routed_inputs;
    logic [2:0] command_source_eff;
    logic [5:0] setpoint_source_onehot;
    logic       fn_write_refused, method2_active;
    dcil_cmd_s  cmd_out;
    dcil_func_s func_out;
    int         err_total = 0, checks = 0, cycles = 0, na, nr;

    dcil_top dcil_top_i (.input0_function_sel(sel0), .input1_function_sel(sel1), .input2_function_sel(sel2),
        .input3_function_sel(sel3), .*);
    dcil_switches dcil_switches_i (.ref_clk(ref_clk), .en_req(en), .run_req(run), .rev_req(rev), .aux_req(aux),
        .digital_in(digital_in));

    // ==========================================
    // Clock and hang guard
    always #12.5 ref_clk = ~ref_clk;
    // Run takes about 300 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // ==========================================
    // Helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [1:0] idx, input logic [6:0] val, input logic [1:0] lvl);
        @(negedge ref_clk);
        param_access_level = lvl;
        fn_write_index = idx;
        fn_write_value = val;
        fn_write = 1'h1;
        @(negedge ref_clk);
        fn_write = 1'h0;
        rf = fn_write_refused;
    endtask
    // Pulses last one cycle, so every cycle of the window is looked at
    task automatic watch(input int n);
        na = 0;
        nr = 0;
        repeat (n) begin
            @(negedge ref_clk);
            na += int'(cmd_out.accel_pulse === 1'h1);
            nr += int'(cmd_out.reverse_pulse === 1'h1);
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        chk("factory functions", 32'h023_048F, 32'({sel0, sel1, sel2, sel3}));
        chk("default source", 32'h6, 32'(command_source_eff));
        $display("test reset done");
    endtask
    task automatic t_sources();
        logic [2:0] sp [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
        for (int i = 1; i < 4; i++) begin
            command_source_sel = 3'(2 * i);
            cyc(2);
            chk("command source", 32'(2 * i), 32'(command_source_eff));
            chk("source flags", 32'h10 >> i, 32'(cmd_out[3:0]));
        end
        for (int i = 0; i < 6; i++) begin
            setpoint_source_sel = sp[i];
            cyc(2);
            chk("setpoint onehot", 32'h1 << i, 32'(setpoint_source_onehot));
        end
        command_source_sel = 3'h2;
        $display("test sources done");
    endtask
    task automatic t_decode();
        logic [6:0] code [18] = '{7'h03, 7'h04, 7'h09, 7'h0A, 7'h0B, 7'h0D, 7'h0E, 7'h16, 7'h17, 7'h18, 7'h19,
                                 7'h1B, 7'h1D, 7'h21, 7'h0F, 7'h10, 7'h11, 7'h12};
        wr(2'h3, 7'h03, 2'h1);
        chk("refused low level", 32'h8F, 32'({rf, sel3}));
        for (int i = 0; i < 18; i++) begin
            wr(2'h3, code[i], 2'h2);
            chk("accepted write", 32'(code[i]), 32'({rf, sel3}));
            aux = 1'h1;
            cyc(4);
            // Coast stop first, fixed-frequency bits last
            chk("decode", i < 14 ? 32'h2_0000 >> i : 32'h1 << (i - 14), 32'({func_out[13:0], fixed_freq_sel}));
            aux = 1'h0;
            cyc(3);
        end
        $display("test decode done");
    endtask
    task automatic t_routed();
        wr(2'h3, 7'h63, 2'h2);
        aux = 1'h1;
        cyc(4);
        chk("routed inputs", 32'h8, 32'(routed_inputs));
        aux = 1'h0;
        wr(2'h3, 7'h01, 2'h2);
        chk("locked selector", 32'hE3, 32'({rf, sel3}));
        @(negedge ref_clk);
        factory_restore = 1'h1;
        @(negedge ref_clk);
        factory_restore = 1'h0;
        chk("restored functions", 32'h023_048F, 32'({sel0, sel1, sel2, sel3}));
        $display("test routed done");
    endtask
    task automatic t_method2();
        wr(2'h0, 7'h02, 2'h2);
        wr(2'h1, 7'h01, 2'h2);
        wr(2'h2, 7'h0C, 2'h2);
        wire_method_sel = 2'h3;
        en = 1'h1;
        rev = 1'h1;
        cyc(4);
        chk("method active", 32'h1, 32'(method2_active));
        run = 1'h1;
        watch(8);
        chk("start edge", 32'h1_11, 32'({na[3:0], 3'h0, cmd_out.run_on, 3'h0, cmd_out.dir_reverse}));
        watch(6);
        chk("held run level", 32'h0, 32'(na));
        motor_stationary = 1'h0;
        run = 1'h0;
        cyc(3);
        rev = 1'h0;
        watch(8);
        chk("reverse to setpoint", 32'h10, 32'({nr[3:0], 3'h0, cmd_out.dir_reverse}));
        rev = 1'h1;
        watch(8);
        chk("reverse to inverted", 32'h11, 32'({nr[3:0], 3'h0, cmd_out.dir_reverse}));
        run = 1'h1;
        watch(8);
        chk("start while rotating", 32'h0, 32'(na));
        run = 1'h0;
        en = 1'h0;
        rev = 1'h0;
        watch(8);
        chk("enable drop", 32'h01, 32'({nr[3:0], cmd_out.run_on, 3'h0, func_out.ramp_stop}));
        motor_stationary = 1'h1;
        run = 1'h1;
        watch(8);
        chk("disabled at standstill", 32'h0, 32'({na[3:0], 3'h0, func_out.ramp_stop}));
        run = 1'h0;
        en = 1'h1;
        cyc(3);
        rev = 1'h1;
        watch(8);
        chk("reverse at standstill", 32'h0, 32'(nr));
        wire_method_sel = 2'h0;
        cyc(2);
        chk("method left", 32'h0, 32'(method2_active));
        $display("test method2 done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        cyc(20);
        reset = 1'h0;
        cyc(2);
        t_reset();
        t_sources();
        t_decode();
        t_routed();
        t_method2();
        tally_and_finish();
    end
endmodule

bind dcil_top dcil_properties #(.HAS_FIELDBUS(HAS_FIELDBUS)) dcil_properties_i (.*);
